// ===== verilog/fwps_map.vh
// Register map, field positions, reset values and timing for the word program sequencer
`ifndef FWPS_MAP_VH
`define FWPS_MAP_VH

// ----------------------------------------
// Register byte offsets (word aligned)
// ----------------------------------------
`define FWPS_OFS_PTR_LOW      8'h00
`define FWPS_OFS_PTR_HIGH     8'h04
`define FWPS_OFS_PTR_UPPER    8'h08
`define FWPS_OFS_LATCH        8'h0C
`define FWPS_OFS_CONTROL      8'h10
`define FWPS_OFS_KEY          8'h14
`define FWPS_OFS_TABLE_OP     8'h18
`define FWPS_OFS_STATUS       8'h1C

// ----------------------------------------
// flash_control field positions
// ----------------------------------------
`define FWPS_CTL_GO           1
`define FWPS_CTL_WRITE_UNLOCK_ENABLE         2
`define FWPS_CTL_FAULT        3
`define FWPS_CTL_ERASE        4
`define FWPS_CTL_WORD         5
`define FWPS_CTL_IMPL_MASK    8'h3E

// ----------------------------------------
// Unlock key values
// ----------------------------------------
`define FWPS_KEY_FIRST        8'h55
`define FWPS_KEY_SECOND       8'hAA

// ----------------------------------------
// table_store_op pointer modes (data bits 1:0)
// ----------------------------------------
`define FWPS_TOP_KEEP         2'h0
`define FWPS_TOP_POST_INC     2'h1
`define FWPS_TOP_POST_DEC     2'h2
`define FWPS_TOP_PRE_INC      2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FWPS_RST_BYTE         8'h00
`define FWPS_RST_PTR          22'h000000

// ----------------------------------------
// Timing
// ----------------------------------------
`define FWPS_CLK_PERIOD_NS    10
`define FWPS_PROG_TIME_NS     1000000
`define FWPS_PROG_CYCLES      (`FWPS_PROG_TIME_NS / `FWPS_CLK_PERIOD_NS)

`endif

// ===== verilog/fwps_top.v
// Flash word program sequencer with classic Wishbone register slave
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "fwps_map.vh"

// Functional notes
// - word mode programs one two-byte word
// - write enable bit 2, word mode bit 5
// - go after unlock with enable starts write
// - CPU stalled for whole program cycle time
// - master clear or watchdog reset during write sets fault flag
// - erase bit4, fault bit3, go bit1, others zero
// - table pointer is 22 bits in three bytes
// - unlock key location stores nothing
// - internal timer ends write without software
// - holding registers never cleared by hardware
module fwps_top #(
    parameter                    PROG_CYCLES = `FWPS_PROG_CYCLES, // Program cycle length in clocks
    parameter                    HOLD_DEPTH  = 64                 // Number of holding bytes
) (
    input  wire                  clk_i,          // Core clock, 100 MHz
    input  wire                  rst_i,          // Device reset, sync, active high
    input  wire                  por_i,          // Power-on reset, clears fault flag
    input  wire                  master_clear_pin_reset_i,   // Reset cause: master clear pin
    input  wire                  wdt_reset_i,    // Reset cause: watchdog time-out
    input  wire                  wb_cyc_i,       // Wishbone cycle
    input  wire                  wb_stb_i,       // Wishbone strobe
    input  wire                  wb_we_i,        // Wishbone write enable
    input  wire [7:0]            wb_adr_i,       // Wishbone byte address
    input  wire [3:0]            wb_sel_i,       // Wishbone byte selects
    input  wire [31:0]           wb_dat_i,       // Wishbone write data
    output reg  [31:0]           wb_dat_o,       // Wishbone read data
    output reg                   wb_ack_o,       // Wishbone acknowledge
    output reg                   cpu_stall_o,    // Halts instruction execution
    output reg                   flash_write_o,  // Long write in progress
    output reg                   flash_word_o,   // Long write is single word
    output reg                   flash_erase_o,  // Long write is an erase
    output reg  [21:0]           flash_addr_o,   // Target address of long write
    output reg  [15:0]           flash_data_o    // Word data for word write
);

    // ----------------------------------------
    // Local constants and state encoding
    // ----------------------------------------
    // One-hot states; counter wide enough for the full cycle
    localparam                   AW       = $clog2(HOLD_DEPTH);
    localparam                   CW       = $clog2(PROG_CYCLES + 1);
    localparam [3:0]             S_IDLE   = 4'h1;
    localparam [3:0]             S_KEY1   = 4'h2;
    localparam [3:0]             S_ARMED  = 4'h4;
    localparam [3:0]             S_BUSY   = 4'h8;
    localparam [31:0]            CYC_LIM  = PROG_CYCLES - 1;
    localparam [CW-1:0]          CYC_LAST = CYC_LIM[CW-1:0];

    // ----------------------------------------
    // Address decode helper
    // ----------------------------------------
    function hit;
        input [7:0]              adr;
        input [7:0]              ofs;
        begin
            hit = (adr[7:2] == ofs[7:2]);
        end
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg  [21:0]                  ptr_q;
    reg  [7:0]                   latch_q;
    reg                          write_unlock_enable_q;
    reg                          word_q;
    reg                          erase_q;
    reg                          go_q;
    reg                          fault_q;
    reg  [3:0]                   state_q;
    reg  [CW-1:0]                cnt_q;
    reg  [7:0]                   hold_q [0:HOLD_DEPTH-1];

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // New request: strobe up, not yet answered
    wire                         req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire                         wr_req = req & wb_we_i & wb_sel_i[0];
    wire [7:0]                   wbyte  = wb_dat_i[7:0];
    // Per-register write strobes
    wire                         wr_ptr_l = wr_req & hit(wb_adr_i, `FWPS_OFS_PTR_LOW);
    wire                         wr_ptr_h = wr_req & hit(wb_adr_i, `FWPS_OFS_PTR_HIGH);
    wire                         wr_ptr_u = wr_req & hit(wb_adr_i, `FWPS_OFS_PTR_UPPER);
    wire                         wr_lat   = wr_req & hit(wb_adr_i, `FWPS_OFS_LATCH);
    wire                         wr_ctl   = wr_req & hit(wb_adr_i, `FWPS_OFS_CONTROL);
    wire                         wr_key   = wr_req & hit(wb_adr_i, `FWPS_OFS_KEY);
    wire                         wr_top   = wr_req & hit(wb_adr_i, `FWPS_OFS_TABLE_OP);
    // Write cycle state, go qualification and holding index
    wire                         busy     = state_q[3];
    wire                         go_ok    = wr_ctl & wbyte[`FWPS_CTL_GO] & wbyte[`FWPS_CTL_WRITE_UNLOCK_ENABLE]
                                            & state_q[2];
    wire [7:0]                   ctl_rd;
    wire [AW-1:0]                widx_hi = {ptr_q[AW-1:1], 1'b1};
    wire [AW-1:0]                widx_lo = {ptr_q[AW-1:1], 1'b0};

    // Control readback; bits 7, 6 and 0 read zero
    assign ctl_rd = {2'b00, word_q, erase_q, fault_q, write_unlock_enable_q, go_q, 1'b0};

    // ----------------------------------------
    // Wishbone acknowledge and read data
    // ----------------------------------------
    // One-cycle ack; read data stands with it
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (req && !wb_we_i) begin
                if (hit(wb_adr_i, `FWPS_OFS_PTR_LOW))
                    wb_dat_o[7:0] <= ptr_q[7:0];
                else if (hit(wb_adr_i, `FWPS_OFS_PTR_HIGH))
                    wb_dat_o[7:0] <= ptr_q[15:8];
                else if (hit(wb_adr_i, `FWPS_OFS_PTR_UPPER))
                    wb_dat_o[7:0] <= {2'b00, ptr_q[21:16]};
                else if (hit(wb_adr_i, `FWPS_OFS_LATCH))
                    wb_dat_o[7:0] <= latch_q;
                else if (hit(wb_adr_i, `FWPS_OFS_CONTROL))
                    wb_dat_o[7:0] <= ctl_rd;
                else if (hit(wb_adr_i, `FWPS_OFS_STATUS))
                    wb_dat_o[3:0] <= state_q;
                // Key location and unmapped words read zero
            end
        end
    end

    // ----------------------------------------
    // Table pointer and table writes
    // ----------------------------------------
    // Pointer bytes, latch and pointer modes
    always @(posedge clk_i) begin
        if (rst_i) begin
            ptr_q   <= `FWPS_RST_PTR;
            latch_q <= `FWPS_RST_BYTE;
        end else begin
            if (wr_ptr_l)
                ptr_q[7:0] <= wbyte;
            if (wr_ptr_h)
                ptr_q[15:8] <= wbyte;
            if (wr_ptr_u)
                ptr_q[21:16] <= wbyte[5:0];
            if (wr_lat)
                latch_q <= wbyte;
            // Table store moves the pointer even while busy
            if (wr_top) begin
                case (wbyte[1:0])
                    `FWPS_TOP_POST_INC,
                    `FWPS_TOP_PRE_INC: begin
                        ptr_q <= ptr_q + 22'h000001;
                    end
                    `FWPS_TOP_POST_DEC: begin
                        ptr_q <= ptr_q - 22'h000001;
                    end
                    default: begin
                        ptr_q <= ptr_q;
                    end
                endcase
            end
        end
    end

    // Holding bytes: never cleared by reset or by a finished write
    always @(posedge clk_i) begin
        if (wr_top && !busy) begin
            if (wbyte[1:0] == `FWPS_TOP_PRE_INC)
                hold_q[ptr_q[AW-1:0] + {{(AW-1){1'b0}}, 1'b1}] <= latch_q;
            else
                hold_q[ptr_q[AW-1:0]] <= latch_q;
        end
    end

    // ----------------------------------------
    // Unlock sequence and write cycle control
    // ----------------------------------------
    // Key pair tracking, then the timed long write
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            cnt_q   <= {CW{1'b0}};
        end else begin
            case (state_q)
                S_IDLE: begin
                    // First key opens the pair
                    if (wr_key && wbyte == `FWPS_KEY_FIRST)
                        state_q <= S_KEY1;
                end
                S_KEY1: begin
                    // Any other write but a repeated first key breaks the key pair
                    if (wr_key && wbyte == `FWPS_KEY_SECOND)
                        state_q <= S_ARMED;
                    else if (wr_req)
                        state_q <= (wr_key && wbyte == `FWPS_KEY_FIRST) ? S_KEY1 : S_IDLE;
                end
                S_ARMED: begin
                    // Only the very next write may carry go
                    if (go_ok) begin
                        state_q <= S_BUSY;
                        cnt_q   <= {CW{1'b0}};
                    end else if (wr_req) begin
                        state_q <= S_IDLE;
                    end
                end
                S_BUSY: begin
                    // Internal timer alone ends the cycle
                    if (cnt_q == CYC_LAST) begin
                        state_q <= S_IDLE;
                        cnt_q   <= {CW{1'b0}};
                    end else begin
                        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    cnt_q   <= {CW{1'b0}};
                end
            endcase
        end
    end

    // ----------------------------------------
    // flash_control bits
    // ----------------------------------------
    // Fault flag: set by a master clear or watchdog reset that cuts a write
    always @(posedge clk_i) begin
        if (por_i) begin
            fault_q <= 1'b0;
        end else if (rst_i) begin
            // Master clear or watchdog reset during a long write leaves the fault mark
            if (busy && (master_clear_pin_reset_i || wdt_reset_i))
                fault_q <= 1'b1;
        end else if (wr_ctl && !wbyte[`FWPS_CTL_FAULT]) begin
            fault_q <= 1'b0;
        end
    end

    // Enable, mode and go bits; fields frozen while busy
    always @(posedge clk_i) begin
        if (rst_i) begin
            write_unlock_enable_q  <= 1'b0;
            word_q  <= 1'b0;
            erase_q <= 1'b0;
            go_q    <= 1'b0;
        end else begin
            if (wr_ctl && !busy) begin
                write_unlock_enable_q  <= wbyte[`FWPS_CTL_WRITE_UNLOCK_ENABLE];
                word_q  <= wbyte[`FWPS_CTL_WORD];
                erase_q <= wbyte[`FWPS_CTL_ERASE];
            end
            if (go_ok)
                go_q <= 1'b1;
            else if (busy && cnt_q == CYC_LAST)
                go_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Flash macro drive and CPU stall
    // ----------------------------------------
    // Targets captured at go, held for the whole cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            cpu_stall_o   <= 1'b0;
            flash_write_o <= 1'b0;
            flash_word_o  <= 1'b0;
            flash_erase_o <= 1'b0;
            flash_addr_o  <= `FWPS_RST_PTR;
            flash_data_o  <= 16'h0000;
        end else begin
            if (go_ok) begin
                cpu_stall_o   <= 1'b1;
                flash_write_o <= 1'b1;
                flash_word_o  <= word_q & ~erase_q;
                flash_erase_o <= erase_q;
                // Word target: even byte of the pair the pointer sits on
                flash_addr_o  <= word_q ? {ptr_q[21:1], 1'b0}
                                        : {ptr_q[21:AW], {AW{1'b0}}};
                flash_data_o  <= {hold_q[widx_hi], hold_q[widx_lo]};
            end else if (busy && cnt_q == CYC_LAST) begin
                cpu_stall_o   <= 1'b0;
                flash_write_o <= 1'b0;
            end
        end
    end

endmodule // fwps_top

// ===== tb/fwps_monitor.sv
// Port checker for the flash word program sequencer
`timescale 1ns/1ns
`include "fwps_map.vh"
module fwps_monitor #(
    parameter           PROG_CYCLES = 8 // Long write length in clocks
) (
    input wire          clk_i,          // Core clock
    input wire          rst_i,          // Device reset
    input wire          por_i,          // Power-on reset
    input wire          master_clear_pin_reset_i,   // Master clear cause
    input wire          wdt_reset_i,    // Watchdog cause
    input wire          wb_cyc_i,       // Bus cycle
    input wire          wb_stb_i,       // Bus strobe
    input wire          wb_we_i,        // Bus write
    input wire [7:0]    wb_adr_i,       // Bus address
    input wire [3:0]    wb_sel_i,       // Bus selects
    input wire [31:0]   wb_dat_i,       // Bus write data
    input wire [31:0]   wb_dat_o,       // Bus read data
    input wire          wb_ack_o,       // Bus acknowledge
    input wire          cpu_stall_o,    // CPU stall
    input wire          flash_write_o,  // Long write active
    input wire          flash_word_o,   // Word mode write
    input wire          flash_erase_o,  // Erase write
    input wire [21:0]   flash_addr_o,   // Write target
    input wire [15:0]   flash_data_o    // Write word
);
    // Request decode
    wire        take_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr_w   = take_w & wb_we_i & wb_sel_i[0];
    wire        ctl_w  = {wb_adr_i[7:2], 2'h0} == `FWPS_OFS_CONTROL;
    wire        key_w  = {wb_adr_i[7:2], 2'h0} == `FWPS_OFS_KEY;
    wire        go_w   = wr_w & ctl_w & (wb_dat_i[2:1] == 2'h3);
    reg  [1:0]  key_q;
    reg  [31:0] cnt_q;
    // Unlock tracker and stall length counter
    always @(posedge clk_i) begin
        if (rst_i) begin
            key_q <= 2'h0;
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cpu_stall_o ? cnt_q + 32'h1 : 32'h0;
            if (wr_w) begin
                key_q <= !key_w ? 2'h0 : (wb_dat_i[7:0] == `FWPS_KEY_FIRST) ? 2'h1 :
                         (wb_dat_i[7:0] == `FWPS_KEY_SECOND && key_q == 2'h1) ? 2'h2 : 2'h0;
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_stall_eq_write: assert property (cpu_stall_o == flash_write_o)
        else $error("stall and write differ");
    a_stall_bound: assert property (cpu_stall_o |-> cnt_q < PROG_CYCLES)
        else $error("stall too long");
    a_stall_len: assert property ($fell(cpu_stall_o) |-> cnt_q == PROG_CYCLES)
        else $error("stall length wrong");
    a_go_cause: assert property ($rose(cpu_stall_o) |-> $past(go_w && key_q == 2'h2))
        else $error("write began without unlock");
    a_go_start: assert property (go_w && key_q == 2'h2 && !cpu_stall_o |=> cpu_stall_o)
        else $error("go did not start write");
    a_go_refuse: assert property (wr_w && ctl_w && key_q != 2'h2 && !cpu_stall_o |=> !cpu_stall_o)
        else $error("go accepted without key");
    a_word_even: assert property (flash_write_o && flash_word_o |-> !flash_addr_o[0])
        else $error("word address odd");
    a_write_hold: assert property (flash_write_o && $past(flash_write_o) |-> $stable(flash_data_o))
        else $error("word data moved");
    a_ctl_read: assert property (wb_ack_o && $past(take_w && !wb_we_i && ctl_w) |->
        wb_dat_o[7:6] == 2'h0 && !wb_dat_o[0] && wb_dat_o[31:8] == 24'h0) else $error("control unused bits set");
    a_key_read: assert property (wb_ack_o && $past(take_w && !wb_we_i && key_w) |-> wb_dat_o == 32'h0)
        else $error("key location stored data");
    c_go: cover property ($rose(cpu_stall_o));
    c_refuse: cover property (wr_w && ctl_w && key_q != 2'h2 && wb_dat_i[1]);
    c_end: cover property ($fell(cpu_stall_o));
endmodule // fwps_monitor
bind fwps_top fwps_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .master_clear_pin_reset_i(master_clear_pin_reset_i), .wdt_reset_i(wdt_reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cpu_stall_o(cpu_stall_o), .flash_write_o(flash_write_o), .flash_word_o(flash_word_o),
    .flash_erase_o(flash_erase_o), .flash_addr_o(flash_addr_o), .flash_data_o(flash_data_o));

// ===== tb/tb.sv
// Self-checking bench for the flash word program sequencer
`timescale 1ns/1ns
`include "fwps_map.vh"
module tb;
    localparam  PROG = 8; // Shortened long write
    reg         clk_i = 0, rst_i = 1, por_i = 1, master_clear_pin_reset_i = 0, wdt_reset_i = 0;
    reg         wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    reg  [7:0]  wb_adr_i = 8'h00;
    reg  [3:0]  wb_sel_i = 4'h0;
    reg  [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o, cpu_stall_o, flash_write_o, flash_word_o, flash_erase_o;
    wire [21:0] flash_addr_o;
    wire [15:0] flash_data_o;
    integer     errors, n_checks, k;
    fwps_top #(.PROG_CYCLES(PROG)) uut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .master_clear_pin_reset_i(master_clear_pin_reset_i),
        .wdt_reset_i(wdt_reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cpu_stall_o(cpu_stall_o), .flash_write_o(flash_write_o), .flash_word_o(flash_word_o),
        .flash_erase_o(flash_erase_o), .flash_addr_o(flash_addr_o), .flash_data_o(flash_data_o));
    // Core clock
    always #5 clk_i = ~clk_i;
    // Compare and count
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // One classic bus cycle; ack and read data taken at the rising edge that sees ack
    task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
        begin
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i  <= w;
            wb_adr_i <= a;
            wb_dat_i <= d;
            wb_sel_i <= 4'hF;
            @(posedge clk_i);
            // Values read here are those this edge samples
            while (wb_ack_o !== 1'b1) begin
                @(posedge clk_i);
            end
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i  <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        reg [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        reg [31:0] q;
        begin
            wb(1'b0, a, 32'h0, q);
            chk(q, exp);
        end
    endtask
    // Unlock pair then go with write enable and word mode
    task go;
        begin
            wr(`FWPS_OFS_KEY, 32'h55);
            wr(`FWPS_OFS_KEY, 32'hAA);
            wr(`FWPS_OFS_CONTROL, 32'h26);
        end
    endtask
    // Word write with captured outputs and stall length
    task run(input [15:0] exp_d);
        integer n;
        begin
            go;
            n = 0;
            @(negedge clk_i);
            chk(flash_addr_o, 32'h12346);
            chk(flash_data_o, exp_d);
            chk({flash_word_o, flash_erase_o, flash_write_o}, 32'h5);
            while (cpu_stall_o === 1'b1 && n < 50) begin
                n = n + 1;
                @(negedge clk_i);
            end
            // First stall cycle elapses inside the go bus cycle
            chk(n + 1, PROG);
        end
    endtask
    task end_of_test;
        begin
            $display("checks=%0d errors=%0d", n_checks, errors);
            if (errors == 0 && n_checks > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    // Watchdog
    initial begin
        repeat (4000) @(posedge clk_i);
        errors = errors + 1;
        end_of_test;
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        errors = 0;
        n_checks = 0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        rd(`FWPS_OFS_CONTROL, 32'h0);
        rd(`FWPS_OFS_KEY, 32'h0);
        rd(`FWPS_OFS_STATUS, 32'h1);
        rd(8'h20, 32'h0);
        wr(`FWPS_OFS_CONTROL, 32'hFF);
        rd(`FWPS_OFS_CONTROL, 32'h34);
        chk(cpu_stall_o, 32'h0);
        wr(`FWPS_OFS_PTR_UPPER, 32'hFF);
        rd(`FWPS_OFS_PTR_UPPER, 32'h3F);
        $display("test map done");
        wr(`FWPS_OFS_PTR_UPPER, 32'h01);
        wr(`FWPS_OFS_PTR_HIGH, 32'h23);
        wr(`FWPS_OFS_PTR_LOW, 32'h46);
        wr(`FWPS_OFS_LATCH, 32'h5A);
        rd(`FWPS_OFS_LATCH, 32'h5A);
        wr(`FWPS_OFS_TABLE_OP, 32'h1);
        wr(`FWPS_OFS_LATCH, 32'hC3);
        wr(`FWPS_OFS_TABLE_OP, 32'h0);
        rd(`FWPS_OFS_PTR_LOW, 32'h47);
        wr(`FWPS_OFS_CONTROL, 32'h24);
        run(16'hC35A);
        rd(`FWPS_OFS_CONTROL, 32'h24);
        run(16'hC35A);
        $display("test word write done");
        wr(`FWPS_OFS_KEY, 32'h55);
        rd(`FWPS_OFS_STATUS, 32'h2);
        wr(`FWPS_OFS_PTR_LOW, 32'h47);
        wr(`FWPS_OFS_KEY, 32'hAA);
        wr(`FWPS_OFS_CONTROL, 32'h26);
        repeat (3) @(negedge clk_i);
        chk(cpu_stall_o, 32'h0);
        $display("test broken key done");
        for (k = 0; k < 3; k = k + 1) begin
            if (k < 2) begin
                wr(`FWPS_OFS_CONTROL, (k == 1) ? 32'h34 : 32'h24);
                go;
                rd(`FWPS_OFS_STATUS, 32'h8);
                chk({flash_word_o, flash_erase_o}, (k == 1) ? 32'h1 : 32'h2);
            end
            repeat (1) @(posedge clk_i);
            rst_i <= 1'b1;
            master_clear_pin_reset_i <= (k != 1);
            wdt_reset_i <= (k == 1);
            repeat (3) @(posedge clk_i);
            rst_i <= 1'b0;
            master_clear_pin_reset_i <= 1'b0;
            wdt_reset_i <= 1'b0;
            rd(`FWPS_OFS_CONTROL, (k < 2) ? 32'h08 : 32'h0);
            wr(`FWPS_OFS_CONTROL, 32'h0);
            rd(`FWPS_OFS_CONTROL, 32'h0);
        end
        $display("test fault done");
        // Rewrite after the cut: reload pointer, keep then pre-increment
        wr(`FWPS_OFS_PTR_UPPER, 32'h01);
        wr(`FWPS_OFS_PTR_HIGH, 32'h23);
        wr(`FWPS_OFS_PTR_LOW, 32'h46);
        wr(`FWPS_OFS_LATCH, 32'h11);
        wr(`FWPS_OFS_TABLE_OP, 32'h0);
        wr(`FWPS_OFS_LATCH, 32'h22);
        wr(`FWPS_OFS_TABLE_OP, 32'h3);
        rd(`FWPS_OFS_PTR_LOW, 32'h47);
        wr(`FWPS_OFS_CONTROL, 32'h24);
        run(16'h2211);
        wr(`FWPS_OFS_TABLE_OP, 32'h2);
        rd(`FWPS_OFS_PTR_LOW, 32'h46);
        wr(`FWPS_OFS_CONTROL, 32'h0);
        rd(`FWPS_OFS_CONTROL, 32'h0);
        $display("test rewrite done");
        end_of_test;
    end
endmodule // tb
